// ===== asc_pkg.sv
// Package for the asynchronous SRAM host controller: timing counts and carrier types
package asc_pkg;
    localparam int ADDR_W = 17;
    localparam int DATA_W = 24;
    localparam int CLK_PERIOD_PS = 20000;
    // Slow grade figures in ps so one controller meets both grades
    localparam int T_RC_PS = 10000;
    localparam int T_AA_PS = 10000;
    localparam int T_DOE_PS = 6500;
    localparam int T_PWE2_PS = 10000;
    localparam int T_SD_PS = 6000;
    localparam int T_AW_PS = 8000;
    localparam int T_SCE_PS = 8000;
    localparam int T_WC_PS = 10000;
    localparam int T_HZOE_PS = 4000;
    // Least times round up, at least one cycle
    localparam int RD_CYC = ((T_AA_PS > T_DOE_PS ? T_AA_PS : T_DOE_PS) + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int WR_CYC = (T_PWE2_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int TURN_CYC = (T_HZOE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CNT_W = 4;
    localparam logic [CNT_W-1:0] RD_CNT = CNT_W'(RD_CYC > 0 ? RD_CYC : 1);
    localparam logic [CNT_W-1:0] WR_CNT = CNT_W'(WR_CYC > 0 ? WR_CYC : 1);
    localparam logic [CNT_W-1:0] TURN_CNT = CNT_W'(TURN_CYC > 0 ? TURN_CYC : 1);

    typedef struct packed {
        logic write;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } asc_req_t;

    typedef struct packed {
        logic chip_select_low_active_n;
        logic chip_select_high_active;
        logic output_gate_n;
        logic write_strobe_n;
        logic [ADDR_W-1:0] word_address;
    } asc_pins_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_READ = 5'h02,
        ST_WSET = 5'h04,
        ST_WRITE = 5'h08,
        ST_TURN = 5'h10
    } asc_state_t;
endpackage

// ===== asc_host.sv
// Host controller driving a 128K x 24 asynchronous SRAM over its pins
`timescale 1ns/10ps
// Summary of operation
// [RULE1] SRAM writes only while low select low, high select high, strobe low.
// [RULE2] Host asserts all three qualifiers to write, ends by dropping one.
// [RULE3] Write data set up before strobe rises; zero hold allowed.
// [RULE4] Address stable before write end; may change right after.
// [RULE5] Strobe low at least 8 or 10 ns with output gate low.
// [RULE6] Strobe low at least 6.5 or 8 ns with output gate high.
// [RULE7] Selects active before write end; writes spaced by write cycle time.
// [RULE8] SRAM floats its outputs shortly after strobe falls.
// [RULE9] SRAM drives no sooner than 2 ns after strobe rises.
// [RULE10] Strobe held high throughout every read cycle.
// [RULE11] Read data valid within access time of address change.
// [RULE12] SRAM holds old read data 2.5 ns after address change.
// [RULE13] Address valid no later than selects become active.
// [RULE14] SRAM drives data after gate falls, floats after gate rises.
// [RULE15] SRAM floats outputs after deselection, drives after selection.
// [RULE16] SRAM deselected when low select high or high select low.
// [RULE17] Write strobe chooses write when low, read when high.
// [RULE18] Memory is 131072 words of 24 bits, 17-bit address.
module asc_host (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic req_valid,
    input wire asc_pkg::asc_req_t req,
    output logic req_ready,
    output logic rsp_valid,
    output logic [asc_pkg::DATA_W-1:0] rsp_data,
    output asc_pkg::asc_pins_t pins,
    output logic [asc_pkg::DATA_W-1:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [asc_pkg::DATA_W-1:0] data_bus_in
);
    asc_pkg::asc_state_t state_q, state_d;
    logic [asc_pkg::CNT_W-1:0] cnt_q, cnt_d;
    asc_pkg::asc_pins_t pins_q, pins_d;
    logic [asc_pkg::DATA_W-1:0] wdata_q, wdata_d;
    logic oe_q, oe_d;
    logic ready_q, ready_d;
    logic rv_q, rv_d;
    logic [asc_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [asc_pkg::DATA_W-1:0] din_s1_q, din_s2_q;

    wire cnt_done = (cnt_q == '0);
    wire take = req_valid && ready_q;
    wire [asc_pkg::CNT_W-1:0] cnt_dec = cnt_q - asc_pkg::CNT_W'(1);
    asc_pkg::asc_pins_t idle_pins;
    assign idle_pins = '{chip_select_low_active_n: 1'b1, chip_select_high_active: 1'b0,
                         output_gate_n: 1'b1, write_strobe_n: 1'b1, word_address: pins_q.word_address};

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_done ? cnt_q : cnt_dec;
        pins_d = pins_q;
        wdata_d = wdata_q;
        oe_d = oe_q;
        ready_d = ready_q;
        rv_d = 1'b0;
        rdata_d = rdata_q;
        case (state_q)
            asc_pkg::ST_IDLE: begin
                if (take && req.write) begin
                    // Address and selects first, strobe next cycle; data driven with strobe low
                    pins_d = '{chip_select_low_active_n: 1'b0, chip_select_high_active: 1'b1,
                               output_gate_n: 1'b1, write_strobe_n: 1'b1, word_address: req.addr}; // see [RULE13]
                    wdata_d = req.wdata;
                    ready_d = 1'b0;
                    state_d = asc_pkg::ST_WSET;
                end else if (take) begin
                    pins_d = '{chip_select_low_active_n: 1'b0, chip_select_high_active: 1'b1,
                               output_gate_n: 1'b0, write_strobe_n: 1'b1, word_address: req.addr}; // see [RULE13]
                    cnt_d = asc_pkg::RD_CNT + asc_pkg::CNT_W'(2); // Extra two for input synchroniser
                    ready_d = 1'b0;
                    state_d = asc_pkg::ST_READ; // see [RULE10]
                end
            end
            asc_pkg::ST_READ: begin
                if (cnt_done) begin
                    rdata_d = din_s2_q; // see [RULE11]
                    rv_d = 1'b1;
                    pins_d = idle_pins; // see [RULE16]
                    cnt_d = asc_pkg::TURN_CNT; // Bus must float before host may drive again
                    state_d = asc_pkg::ST_TURN;
                end
            end
            asc_pkg::ST_WSET: begin
                pins_d.write_strobe_n = 1'b0; // see [RULE2]
                oe_d = 1'b1; // see [RULE8]
                cnt_d = asc_pkg::WR_CNT;
                state_d = asc_pkg::ST_WRITE;
            end
            asc_pkg::ST_WRITE: begin
                if (cnt_done) begin
                    // Strobe ends the write while data, address and selects stay put
                    pins_d.write_strobe_n = 1'b1; // see [RULE3]
                    cnt_d = asc_pkg::TURN_CNT;
                    state_d = asc_pkg::ST_TURN;
                end
            end
            asc_pkg::ST_TURN: begin
                oe_d = 1'b0; // see [RULE9]
                pins_d = idle_pins;
                if (cnt_done) begin
                    ready_d = 1'b1; // see [RULE7]
                    state_d = asc_pkg::ST_IDLE;
                end
            end
            default: begin
                state_d = asc_pkg::ST_IDLE;
                pins_d = idle_pins;
                oe_d = 1'b0;
                ready_d = 1'b1;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        din_s1_q <= data_bus_in;
        din_s2_q <= din_s1_q;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_q <= asc_pkg::ST_IDLE;
            cnt_q <= '0;
            pins_q <= '{chip_select_low_active_n: 1'b1, chip_select_high_active: 1'b0,
                        output_gate_n: 1'b1, write_strobe_n: 1'b1, word_address: '0};
            wdata_q <= '0;
            oe_q <= 1'b0;
            ready_q <= 1'b1;
            rv_q <= 1'b0;
            rdata_q <= '0;
        end else if (clk_en) begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            pins_q <= pins_d;
            wdata_q <= wdata_d;
            oe_q <= oe_d;
            ready_q <= ready_d;
            rv_q <= rv_d;
            rdata_q <= rdata_d;
        end
    end

    assign pins = pins_q;
    assign data_bus_out = wdata_q;
    assign data_bus_oe = oe_q;
    assign req_ready = ready_q;
    assign rsp_valid = rv_q;
    assign rsp_data = rdata_q;

    // Assertions
    wire write_on = !pins_q.chip_select_low_active_n && pins_q.chip_select_high_active && !pins_q.write_strobe_n;
    sequence strobe_fall_s;
        $fell(pins_q.write_strobe_n);
    endsequence
    sequence strobe_rise_s;
        $rose(pins_q.write_strobe_n);
    endsequence

    read_strobe_high_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE10]
        !pins_q.output_gate_n |-> pins_q.write_strobe_n) else $error("strobe low during read");
    write_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE1]
        write_on |-> oe_q) else $error("write without data driven");
    strobe_width_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en) // see [RULE5]
        strobe_fall_s |-> !pins_q.write_strobe_n [*2]) else $error("strobe pulse too short");
    data_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE3]
        strobe_rise_s |-> oe_q && $stable(wdata_q)) else $error("data dropped at write end");
    addr_stable_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE4]
        !pins_q.write_strobe_n |-> $stable(pins_q.word_address)) else $error("address moved in write");
    select_write_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE7]
        strobe_fall_s |-> $past(!pins_q.chip_select_low_active_n) && $past(pins_q.chip_select_high_active))
        else $error("selects late for write");
    release_turn_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE9]
        !pins_q.output_gate_n |-> !oe_q) else $error("bus contention on read");
    // Gate falls with the load of the counter; three counts, the capture, then the flop
    read_done_a: assert property (@(posedge sys_clk) disable iff (rst || !clk_en) // see [RULE11]
        $fell(pins_q.output_gate_n) |-> ##4 rsp_valid) else $error("read answer late");
    gate_strobe_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE6]
        !pins_q.write_strobe_n |-> pins_q.output_gate_n) else $error("gate low during write");

    // Ready only ever shows with the memory deselected and the bus released
    ready_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE16]
        req_ready |-> pins_q.chip_select_low_active_n && !pins_q.chip_select_high_active && !oe_q)
        else $error("ready while memory selected");

    // Data goes out on the same edge as the strobe, gate kept high so the memory floats
    drive_with_strobe_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE8]
        strobe_fall_s |-> oe_q && pins_q.output_gate_n) else $error("strobe without data");

    // Address must not move while the memory is presenting read data
    read_addr_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE11]
        !pins_q.output_gate_n && $past(!pins_q.output_gate_n) |-> $stable(pins_q.word_address))
        else $error("address moved in read");

    // Turnaround and the request handshake keep strobes apart by the write cycle time
    write_space_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE7]
        strobe_rise_s |-> pins_q.write_strobe_n [*3]) else $error("writes too close");

    // The answer leaves the memory deselected with its outputs off
    rsp_idle_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE16]
        rsp_valid |-> pins_q.chip_select_low_active_n && pins_q.output_gate_n)
        else $error("answer while selected");

    // Both selects move together, so no half-selected cycle reaches the memory
    select_pair_a: assert property (@(posedge sys_clk) disable iff (rst) // see [RULE13]
        $fell(pins_q.chip_select_low_active_n) |-> pins_q.chip_select_high_active)
        else $error("selects split");
endmodule

// ===== asc_sram_model.sv
// Behavioural 128K x 24 asynchronous SRAM on the far side of the host
`timescale 1ns/10ps
module asc_sram_model (
    input wire logic sys_clk,
    input wire asc_pkg::asc_pins_t pins,
    input wire logic [asc_pkg::DATA_W-1:0] data_bus_out,
    input wire logic data_bus_oe,
    output logic [asc_pkg::DATA_W-1:0] data_bus_in,
    output logic fight
);
    logic [asc_pkg::DATA_W-1:0] mem [0:131071];
    logic [asc_pkg::DATA_W-1:0] last_q = '0;
    wire logic sel = !pins.chip_select_low_active_n && pins.chip_select_high_active;
    wire logic wr = sel && !pins.write_strobe_n;
    // Drives at once when selected with gate low and strobe high: harsher than the part, any late host release shows as a fight
    wire logic rd = sel && pins.write_strobe_n && !pins.output_gate_n;
    assign fight = rd && data_bus_oe;
    // Released bus toggles every cycle so a stale value never passes for data
    assign data_bus_in = data_bus_oe ? data_bus_out : (rd ? mem[pins.word_address] : ~last_q);
    always @(negedge wr) mem[pins.word_address] = data_bus_out;
    always @(posedge sys_clk) last_q <= data_bus_in;
endmodule

// ===== tb_top.sv
// Self-checking bench for the asynchronous SRAM host controller
`timescale 1ns/10ps
module tb_top;
    typedef struct packed {
        asc_pkg::asc_req_t rq;
        logic [asc_pkg::DATA_W-1:0] exp;
        logic stall;
    } asc_row_t;
    localparam asc_pkg::asc_pins_t IDLE = {1'h1, 1'h0, 1'h1, 1'h1, 17'h00000};
    logic sys_clk = 1'h0;
    logic rst = 1'h1;
    logic clk_en = 1'h1;
    logic req_valid = 1'h0;
    asc_pkg::asc_req_t req = '0;
    logic req_ready, rsp_valid, data_bus_oe, fight;
    logic [asc_pkg::DATA_W-1:0] rsp_data, data_bus_out, data_bus_in;
    asc_pkg::asc_pins_t pins;
    int err_total = 0;
    int comparisons = 0;
    asc_row_t rows [6] = '{'{{1'h1, 17'h00000, 24'hA5A5A5}, 24'h0, 1'h1}, '{{1'h1, 17'h1FFFF, 24'h5A5A5A}, 24'h0, 1'h0},
        '{{1'h1, 17'h00001, 24'hFFFFFF}, 24'h0, 1'h0}, '{{1'h0, 17'h00000, 24'h0}, 24'hA5A5A5, 1'h1},
        '{{1'h0, 17'h1FFFF, 24'h0}, 24'h5A5A5A, 1'h0}, '{{1'h0, 17'h00001, 24'h0}, 24'hFFFFFF, 1'h0}};
    asc_host i_dut (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .req_valid(req_valid), .req(req),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .pins(pins),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in));
    asc_sram_model i_mem (.sys_clk(sys_clk), .pins(pins), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in), .fight(fight));
    always #10 sys_clk = ~sys_clk;
    task automatic complete_run();
        $display("errors %0d, comparisons %0d", err_total, comparisons);
        if (err_total == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic mismatch(input string msg);
        err_total++;
        $display("unexpected at %0t: %s", $time, msg);
    endtask
    task automatic chk_data(input logic [23:0] got, input logic [23:0] exp);
        comparisons++;
        if (got !== exp) mismatch($sformatf("data %h, want %h", got, exp));
    endtask
    task automatic chk_pins(input asc_pkg::asc_pins_t got, input asc_pkg::asc_pins_t exp);
        comparisons++;
        if (got !== exp) mismatch($sformatf("pins %h, want %h", got, exp));
    endtask
    // Looks at the falling edge, where the flag is settled, and returns at the rising edge that samples it
    task automatic wait_hi(input bit rsp);
        for (int n = 0; n < 20; n++) begin
            @(negedge sys_clk);
            if ((rsp ? rsp_valid : req_ready) === 1'h1) begin
                @(posedge sys_clk);
                return;
            end
        end
        mismatch("wait ran out");
        complete_run();
    endtask
    task automatic send(input asc_row_t r);
        asc_pkg::asc_pins_t p;
        req_valid <= 1'h1;
        req <= r.rq;
        wait_hi(1'b0);
        req_valid <= 1'h0;
        if (r.stall) begin
            clk_en <= 1'h0;
            #1 p = pins;
            chk_pins(p, {1'h0, 1'h1, r.rq.write, 1'h1, r.rq.addr});
            repeat (6) @(posedge sys_clk) chk_pins(pins, p);
            clk_en <= 1'h1;
        end
        if (!r.rq.write) begin
            wait_hi(1'b1);
            chk_data(rsp_data, r.exp);
        end
        wait_hi(1'b0);
    endtask
    always @(posedge sys_clk) if (fight === 1'h1) mismatch("bus driven by both ends");
    initial begin
        repeat (10) @(posedge sys_clk);
        chk_pins(pins, IDLE);
        chk_data(24'({data_bus_oe, req_ready, rsp_valid}), 24'h000002);
        chk_data(rsp_data, 24'h000000);
        rst <= 1'h0;
        foreach (rows[i]) send(rows[i]);
        // Request held while busy must be ignored
        req_valid <= 1'h1;
        req <= {1'h1, 17'h00002, 24'h123456};
        wait_hi(1'b0);
        req <= {1'h1, 17'h00002, 24'hBAD0BA};
        repeat (2) @(posedge sys_clk);
        req_valid <= 1'h0;
        wait_hi(1'b0);
        send({{1'h0, 17'h00002, 24'h0}, 24'h123456, 1'h0});
        // Reset in mid-read returns the pins to idle
        req_valid <= 1'h1;
        req <= {1'h0, 17'h1FFFF, 24'h0};
        wait_hi(1'b0);
        req_valid <= 1'h0;
        rst <= 1'h1;
        repeat (2) @(posedge sys_clk);
        #1 chk_pins(pins, IDLE);
        @(posedge sys_clk);
        rst <= 1'h0;
        send({{1'h0, 17'h1FFFF, 24'h0}, 24'h5A5A5A, 1'h0});
        complete_run();
    end
endmodule
